// file: rtl/gear_cam_map.vh
`ifndef GEAR_CAM_MAP_VH
`define GEAR_CAM_MAP_VH
// gear ratio: signed, four decimal places, scale 10000
`define RATIO_SCALE 32'sd10000
`define RATIO_MAX 32'sd1279999
// cam limits
`define MASTER_CYCLE_MAX 32'h007F_FFFF
`define SLAVE_CHANGE_MAX 32'h7FFF_FFFF
`define CAM_POINTS 257
`define CAM_IDX_W 9
// master source codes
`define SRC_AUX 2'h0
`define SRC_VECTOR 2'h1
`define SRC_VIRTUAL 2'h2
`endif

// file: rtl/gearing_and_cam_follower.v
`timescale 1ns/10ps
`include "gear_cam_map.vh"
module gearing_and_cam_follower #(
  parameter IDX_W = `CAM_IDX_W
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // master position sources
  input wire signed [31:0] auxiliary_encoder_source,
  input wire signed [31:0] vector_source,
  input wire signed [31:0] virtual_source,
  // gearing configuration
  input wire [1:0] gear_master_select,
  input wire signed [31:0] gear_ratio_set,
  input wire gear_ratio_load,
  input wire gantry_option,
  input wire [31:0] gear_ramp_distance,
  // stop events and independent move
  input wire stop_command,
  input wire limit_hit,
  input wire signed [31:0] independent_move,
  // trippoints
  input wire signed [31:0] reverse_position_trippoint,
  input wire reverse_trip_arm,
  input wire signed [31:0] forward_position_trippoint,
  input wire forward_trip_arm,
  // cam configuration
  input wire cam_master_select,
  input wire [31:0] master_cycle_modulus,
  input wire [31:0] slave_cycle_change,
  input wire slave_change_negative,
  input wire [31:0] cam_interval_width,
  input wire [31:0] cam_phase_offset,
  input wire [IDX_W-1:0] cam_table_index,
  input wire signed [31:0] cam_table_entry,
  input wire cam_table_write,
  input wire cam_mode_enable,
  input wire signed [31:0] cam_engage_point,
  input wire cam_engage_arm,
  input wire signed [31:0] cam_disengage_point,
  input wire cam_disengage_arm,
  // status and output
  output reg signed [31:0] slave_position,
  output reg signed [31:0] gear_phase_lag,
  output reg gearing_active,
  output reg cam_engaged,
  output reg [31:0] cam_master_position,
  output reg command_hold
);

// ==========================================================
// master selection and deltas
reg signed [31:0] gmaster_prev_reg;
reg signed [31:0] cmaster_prev_reg;
reg signed [31:0] gsrc;
always @*
begin
  case (gear_master_select)
    `SRC_AUX: gsrc = auxiliary_encoder_source;
    `SRC_VECTOR: gsrc = vector_source;
    `SRC_VIRTUAL: gsrc = virtual_source;
    default: gsrc = auxiliary_encoder_source;
  endcase
end
// cam master only aux or virtual
wire signed [31:0] csrc = cam_master_select ? virtual_source
  : auxiliary_encoder_source;
wire signed [31:0] gdelta = gsrc - gmaster_prev_reg;
wire signed [31:0] cdelta = csrc - cmaster_prev_reg;

// ==========================================================
// gearing with ramp
reg signed [31:0] ratio_reg;
reg signed [31:0] ratio_old_reg;
reg signed [31:0] ratio_new_reg;
reg [31:0] ramp_done_reg;
reg [31:0] ramp_len_reg;
reg signed [63:0] gear_acc_reg; // position scaled by 10000
reg signed [63:0] ideal_acc_reg;
wire signed [31:0] clip_ratio = (gear_ratio_set > `RATIO_MAX) ? `RATIO_MAX
  : (gear_ratio_set < -`RATIO_MAX) ? -`RATIO_MAX : gear_ratio_set;
wire [31:0] gmag = gdelta[31] ? -gdelta : gdelta;
wire ramping = ramp_done_reg < ramp_len_reg;
wire [31:0] ramp_done_next = (ramp_done_reg + gmag > ramp_len_reg)
  ? ramp_len_reg : ramp_done_reg + gmag;
// proportional ratio through the ramp
wire signed [63:0] ratio_span = ratio_new_reg - ratio_old_reg;
wire signed [63:0] ratio_ramp = (ramp_len_reg == 32'h0000_0000)
  ? $signed({{32{ratio_new_reg[31]}}, ratio_new_reg})
  : ratio_old_reg + (ratio_span * $signed({32'h0000_0000, ramp_done_next}))
    / $signed({32'h0000_0000, ramp_len_reg});
wire gear_stop = limit_hit | stop_command;
wire signed [63:0] gstep = ratio_reg * gdelta;
wire signed [63:0] istep = ratio_new_reg * gdelta;
// scaled-down travel, cut to the output width on purpose
wire signed [63:0] gear_pos_full = gear_acc_reg / `RATIO_SCALE;
wire signed [31:0] gear_pos = gear_pos_full[31:0];
wire signed [63:0] lag_full = (ideal_acc_reg + istep - gear_acc_reg - gstep)
  / `RATIO_SCALE;

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    ratio_reg <= 32'h0000_0000;
    ratio_old_reg <= 32'h0000_0000;
    ratio_new_reg <= 32'h0000_0000;
    ramp_done_reg <= 32'h0000_0000;
    ramp_len_reg <= 32'h0000_0000;
    gear_acc_reg <= 64'h0000_0000_0000_0000;
    ideal_acc_reg <= 64'h0000_0000_0000_0000;
    gearing_active <= 1'b0;
    gear_phase_lag <= 32'h0000_0000;
    gmaster_prev_reg <= 32'h0000_0000;
  end
  else
  begin
    gmaster_prev_reg <= gsrc;
    if (gear_ratio_load)
    begin
      // accepted any time, even in motion
      ratio_old_reg <= ratio_reg;
      ratio_new_reg <= clip_ratio;
      ramp_len_reg <= gear_ramp_distance;
      ramp_done_reg <= 32'h0000_0000;
      gearing_active <= (clip_ratio != 32'h0000_0000);
      if (gear_ramp_distance == 32'h0000_0000)
        ratio_reg <= clip_ratio;
    end
    else if (gear_stop && !gantry_option)
    begin
      gearing_active <= 1'b0;
      ratio_reg <= 32'h0000_0000;
      ratio_new_reg <= 32'h0000_0000;
      ramp_len_reg <= 32'h0000_0000;
    end
    else if (gearing_active || ramping)
    begin
      gear_acc_reg <= gear_acc_reg + gstep;
      ideal_acc_reg <= ideal_acc_reg + istep;
      if (ramping)
      begin
        ramp_done_reg <= ramp_done_next;
        ratio_reg <= ratio_ramp[31:0];
      end
      // lag of ramped travel behind instant change
      gear_phase_lag <= lag_full[31:0];
    end
  end
end

// ==========================================================
// cam table storage
reg signed [31:0] table_reg [0:`CAM_POINTS-1];
genvar gi;
generate
  for (gi = 0; gi < `CAM_POINTS; gi = gi + 1)
  begin : cam_tab
    always @(posedge clk or posedge rst)
    begin
      if (rst)
        table_reg[gi] <= 32'h0000_0000;
      else if (cam_table_write && cam_table_index == gi)
        table_reg[gi] <= cam_table_entry;
    end
  end
endgenerate

// ==========================================================
// cam position and interpolation
wire [31:0] mcyc = (master_cycle_modulus > `MASTER_CYCLE_MAX)
  ? `MASTER_CYCLE_MAX : master_cycle_modulus;
wire [31:0] scyc = (slave_cycle_change > `SLAVE_CHANGE_MAX)
  ? `SLAVE_CHANGE_MAX : slave_cycle_change;
wire [32:0] mpos_raw = {1'b0, cam_master_position}
  + {cdelta[31], cdelta};
// wrap master modulo cycle in either direction
wire [31:0] mpos_wrap = mpos_raw[32] ? mpos_raw[31:0] + mcyc
  : (mpos_raw[31:0] >= mcyc) ? mpos_raw[31:0] - mcyc
  : mpos_raw[31:0];
wire cycle_wrap = (mpos_raw[32] || mpos_raw[31:0] >= mcyc);
wire [31:0] iw = (cam_interval_width == 32'h0000_0000) ? 32'h0000_0001
  : cam_interval_width;
wire [31:0] mshift = (mpos_wrap + cam_phase_offset) % mcyc;
wire [31:0] iq = mshift / iw;
wire [31:0] ir = mshift % iw;
wire [31:0] last_seg = `CAM_POINTS - 2;
wire [IDX_W-1:0] ia = (iq >= `CAM_POINTS - 1) ? last_seg[IDX_W-1:0]
  : iq[IDX_W-1:0];
wire [IDX_W-1:0] ib = ia + {{(IDX_W-1){1'b0}}, 1'b1};
wire signed [31:0] pa = table_reg[ia];
wire signed [31:0] pb = table_reg[ib];
wire signed [63:0] interp = pa + ((pb - pa) * $signed({32'h0, ir}))
  / $signed({32'h0, iw});
wire signed [31:0] sgn_scyc = slave_change_negative ? -scyc : scyc;
wire signed [31:0] cam_target = interp[31:0];
wire signed [31:0] cam_step = slave_change_negative ? -cam_target
  : cam_target;
wire signed [31:0] eng_base = (scyc == 32'h0) ? slave_position
  : slave_position - (slave_position % $signed(scyc));
wire eng_out = (cam_engage_point < 0) ||
  (cam_engage_point >= $signed(mcyc));
wire dis_out = (cam_disengage_point < 0) ||
  (cam_disengage_point >= $signed(mcyc));
// master landing on a point, or passing it upward with no wrap, during this step
function crossed;
  input [31:0] from_p;
  input [31:0] to_p;
  input signed [31:0] pt;
  begin
    crossed = (pt == $signed(to_p)) ||
      ($signed(from_p) < pt && pt < $signed(to_p));
  end
endfunction

reg eng_arm_reg;
reg dis_arm_reg;
reg signed [31:0] cam_base_reg;
reg signed [31:0] cam_out_reg;
// base after this step's wrap, so the cycle seam shows no dip
wire signed [31:0] base_now = !cycle_wrap ? cam_base_reg
  : mpos_raw[32] ? cam_base_reg - sgn_scyc : cam_base_reg + sgn_scyc;
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    cam_master_position <= 32'h0000_0000;
    cmaster_prev_reg <= 32'h0000_0000;
    cam_engaged <= 1'b0;
    eng_arm_reg <= 1'b0;
    dis_arm_reg <= 1'b0;
    cam_base_reg <= 32'h0000_0000;
    cam_out_reg <= 32'h0000_0000;
  end
  else
  begin
    cmaster_prev_reg <= csrc;
    if (!cam_mode_enable)
    begin
      cam_engaged <= 1'b0;
      eng_arm_reg <= 1'b0;
      dis_arm_reg <= 1'b0;
      // switching the cam off leaves the slave where it is
      if (cam_engaged)
        cam_base_reg <= cam_out_reg - gear_pos;
    end
    else
    begin
      cam_master_position <= mpos_wrap;
      if (cam_engage_arm)
        eng_arm_reg <= 1'b1;
      if (cam_disengage_arm)
        dis_arm_reg <= 1'b1;
      if (eng_arm_reg && !cam_engaged &&
        (eng_out || crossed(cam_master_position, mpos_wrap,
        cam_engage_point)))
      begin
        cam_engaged <= 1'b1;
        eng_arm_reg <= 1'b0;
        // slave less its remainder modulo one slave cycle, output starts at that plus cam_step
        cam_base_reg <= eng_base;
        cam_out_reg <= eng_base + cam_step;
      end
      else if (dis_arm_reg && cam_engaged &&
        (dis_out || crossed(cam_master_position, mpos_wrap,
        cam_disengage_point)))
      begin
        cam_engaged <= 1'b0;
        dis_arm_reg <= 1'b0;
        // slave stays where the cam left it
        cam_base_reg <= cam_out_reg - gear_pos;
      end
      else if (cam_engaged)
      begin
        // slave is base plus the interpolated table value (minus it when slave_change_negative), base steps by the slave change at the seam
        cam_out_reg <= base_now + cam_step;
        cam_base_reg <= base_now;
      end
    end
  end
end

// ==========================================================
// output sum and trippoints
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    slave_position <= 32'h0000_0000;
    command_hold <= 1'b0;
  end
  else
  begin
    // geared or cam part plus independent move
    slave_position <= (cam_engaged ? cam_out_reg
      : gear_pos + cam_base_reg) + independent_move;
    if (reverse_trip_arm || forward_trip_arm)
      command_hold <= 1'b1;
    else if (command_hold &&
      ((slave_position < reverse_position_trippoint) ||
      (slave_position > forward_position_trippoint)))
      command_hold <= 1'b0;
  end
end

endmodule // gearing_and_cam_follower

// file: tb/master_axis_model.sv
`timescale 1ns/10ps
// ====================
// virtual master axis
module master_axis_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // step in, position out
  input wire logic signed [31:0] step,
  output logic signed [31:0] pos
);
  // integrate the commanded step each sample
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      pos <= 32'sh0000_0000;
    else
      pos <= pos + step;
  end
endmodule // master_axis_model

// file: tb/gearing_and_cam_follower_chk.sv
`timescale 1ns/10ps
// ====================
// follower checker
module gear_cam_checker (
  // clock and reset
  input wire clk,
  input wire rst,
  // controls
  input wire signed [31:0] gear_ratio_set,
  input wire gear_ratio_load,
  input wire gantry_option,
  input wire stop_command,
  input wire limit_hit,
  input wire forward_trip_arm,
  input wire reverse_trip_arm,
  input wire cam_mode_enable,
  input wire signed [31:0] cam_engage_point,
  input wire cam_engage_arm,
  input wire signed [31:0] cam_disengage_point,
  input wire cam_disengage_arm,
  // status
  input wire gearing_active,
  input wire cam_engaged,
  input wire command_hold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // gearing on and off
  chk_ratio_engages: assert property (gear_ratio_load && gear_ratio_set != 0
    && !stop_command && !limit_hit |=> gearing_active) else $error("no engage");
  chk_zero_ratio_off: assert property (gear_ratio_load
    && gear_ratio_set == 0 |=> !gearing_active) else $error("zero ratio on");
  chk_stop_ends: assert property (gearing_active && !gantry_option
    && stop_command && !gear_ratio_load |=> !gearing_active) else $error("stop");
  chk_gantry_holds: assert property (gearing_active && gantry_option
    && !gear_ratio_load |=> gearing_active) else $error("gantry dropped");
  // cam engage and release
  chk_cam_refused: assert property (!cam_mode_enable [*2]
    |-> !cam_engaged) else $error("cam engaged while off");
  chk_engage_outside: assert property (cam_mode_enable && cam_engage_arm
    && cam_engage_point < 0 |-> ##[1:4] cam_engaged) else $error("no engage");
  chk_quit_outside: assert property (cam_engaged && cam_disengage_arm
    && cam_disengage_point < 0 |-> ##[1:4] !cam_engaged) else $error("no stop");
  // trippoint hold
  chk_hold_on_arm: assert property ($rose(forward_trip_arm
    || reverse_trip_arm) |=> command_hold) else $error("no hold");
endmodule // gear_cam_checker

bind gearing_and_cam_follower gear_cam_checker chk_i (.clk, .rst,
  .gear_ratio_set, .gear_ratio_load, .gantry_option, .stop_command,
  .limit_hit, .forward_trip_arm, .reverse_trip_arm, .cam_mode_enable,
  .cam_engage_point, .cam_engage_arm, .cam_disengage_point,
  .cam_disengage_arm, .gearing_active, .cam_engaged, .command_hold);

// file: tb/gearing_and_cam_follower_tb.sv
`timescale 1ns/10ps
// ====================
// follower bench
module gearing_and_cam_follower_tb;
  logic clk, rst, gear_ratio_load, gantry_option, stop_command, limit_hit;
  logic reverse_trip_arm, forward_trip_arm, cam_master_select;
  logic slave_change_negative, cam_table_write, cam_mode_enable;
  logic cam_engage_arm, cam_disengage_arm, gearing_active, cam_engaged;
  logic command_hold;
  logic [1:0] gear_master_select;
  logic [8:0] cam_table_index;
  logic [31:0] gear_ramp_distance, master_cycle_modulus, slave_cycle_change;
  logic [31:0] cam_interval_width, cam_phase_offset, cam_master_position;
  logic signed [31:0] auxiliary_encoder_source, vector_source, step;
  logic signed [31:0] virtual_source, gear_ratio_set, independent_move;
  logic signed [31:0] reverse_position_trippoint, forward_position_trippoint;
  logic signed [31:0] cam_table_entry, cam_engage_point, cam_disengage_point;
  logic signed [31:0] slave_position, gear_phase_lag, exp_pos, ratio_now;
  integer failures = 0, n_tests = 0, cycles = 0;

  master_axis_model axis (.clk, .rst, .step, .pos(virtual_source));
  gearing_and_cam_follower dut (
    .clk, .rst, .auxiliary_encoder_source, .vector_source, .virtual_source,
    .gear_master_select, .gear_ratio_set, .gear_ratio_load, .gantry_option,
    .gear_ramp_distance, .stop_command, .limit_hit, .independent_move,
    .reverse_position_trippoint, .reverse_trip_arm,
    .forward_position_trippoint, .forward_trip_arm, .cam_master_select,
    .master_cycle_modulus, .slave_cycle_change, .slave_change_negative,
    .cam_interval_width, .cam_phase_offset, .cam_table_index,
    .cam_table_entry, .cam_table_write, .cam_mode_enable, .cam_engage_point,
    .cam_engage_arm, .cam_disengage_point, .cam_disengage_arm,
    .slave_position, .gear_phase_lag, .gearing_active, .cam_engaged,
    .cam_master_position, .command_hold);

  // ====================
  // clock and timeout
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures = failures + 1;
      conclude();
    end
  end

  // ====================
  // helpers
  task automatic tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic signed [31:0] seen, exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("[ERR] %0t saw %0d expected %0d", $time, seen, exp);
    end
  endtask
  task automatic move(input logic signed [31:0] s, input integer n);
    exp_pos = exp_pos + ratio_now * s * n / 10000;
    step <= s;
    tick(n);
    step <= 32'sh0000_0000;
    tick(4);
  endtask
  task automatic load(input logic signed [31:0] r);
    ratio_now = r;
    gear_ratio_set <= r;
    gear_ratio_load <= 1'b1;
    tick(1);
    gear_ratio_load <= 1'b0;
    tick(2);
  endtask
  task automatic halt(input logic g);
    gantry_option <= g;
    stop_command <= 1'b1;
    limit_hit <= g;
    tick(1);
    stop_command <= 1'b0;
    limit_hit <= 1'b0;
    tick(2);
  endtask
  task automatic cam_arm(input logic eng);
    cam_engage_arm <= eng;
    cam_disengage_arm <= !eng;
    tick(1);
    cam_engage_arm <= 1'b0;
    cam_disengage_arm <= 1'b0;
    tick(4);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ====================
  // scenarios
  task automatic gear_follow;
    gear_master_select <= 2'h2;
    load(32'sh0000_C350);
    check(gearing_active, 1);
    move(32'sh0000_000A, 10);
    check(slave_position, exp_pos);
    move(-32'sh0000_000A, 4);
    check(slave_position, exp_pos);
    load(32'sh0000_3039);
    move(32'sh0000_0064, 100);
    check(slave_position, exp_pos);
    check(gear_phase_lag, 0);
    independent_move <= 32'sh0000_0007;
    exp_pos = exp_pos + 7;
    move(32'sh0000_0064, 10);
    check(slave_position, exp_pos);
  endtask
  task automatic gear_stop;
    halt(1'b0);
    check(gearing_active, 0);
    ratio_now = 0;
    move(32'sh0000_0064, 10);
    check(slave_position, exp_pos);
    load(32'sh0000_C350);
    halt(1'b1);
    check(gearing_active, 1);
    move(32'sh0000_000A, 10);
    check(slave_position, exp_pos);
    load(32'sh0000_0000);
    check(gearing_active, 0);
    move(32'sh0000_000A, 10);
    check(slave_position, exp_pos);
  endtask
  task automatic gear_ramp;
    gear_ramp_distance <= 32'h0000_0064;
    load(32'sh0000_2710);
    ratio_now = 0;
    move(32'sh0000_000A, 10);
    // ratio climbs a tenth per 10 counts: 10 x (0 + .1 + ... + .9)
    exp_pos = exp_pos + 45;
    check(slave_position, exp_pos);
    check(gear_phase_lag, 32'sh0000_0037);
    ratio_now = 32'sh0000_2710;
    move(32'sh0000_000A, 2);
    check(slave_position, exp_pos);
    gear_ramp_distance <= 32'h0000_0000;
    load(32'sh0000_0000);
  endtask
  task automatic trip(input logic signed [31:0] fwd, rev, mv, input logic up);
    forward_position_trippoint <= fwd;
    reverse_position_trippoint <= rev;
    forward_trip_arm <= up;
    reverse_trip_arm <= !up;
    tick(1);
    forward_trip_arm <= 1'b0;
    reverse_trip_arm <= 1'b0;
    tick(2);
    check(command_hold, 1);
    independent_move <= independent_move + mv;
    exp_pos = exp_pos + mv;
    tick(4);
    check(command_hold, 0);
    check(slave_position, exp_pos);
  endtask
  task automatic cam_run;
    logic signed [31:0] tbl [4];
    tbl = '{32'sh0000_0000, 32'sh0000_0BB8, 32'sh0000_08CA, 32'sh0000_05DC};
    cam_master_select <= 1'b1;
    master_cycle_modulus <= 32'h0000_1770;
    slave_cycle_change <= 32'h0000_05DC;
    cam_interval_width <= 32'h0000_07D0;
    for (int i = 0; i < 4; i++)
    begin
      cam_table_index <= i[8:0];
      cam_table_entry <= tbl[i];
      cam_table_write <= 1'b1;
      tick(1);
    end
    cam_table_write <= 1'b0;
    cam_engage_point <= -32'sh0000_0001;
    cam_disengage_point <= -32'sh0000_0001;
    cam_arm(1'b1);
    check(cam_engaged, 0);
    cam_mode_enable <= 1'b1;
    cam_arm(1'b1);
    check(cam_engaged, 1);
    move(32'sh0000_03E8, 7);
    check(cam_master_position, 32'sh0000_03E8);
    // whole slave cycles below start, one wrap, half of 3000 at master 1000
    exp_pos = exp_pos - exp_pos % 1500 + 3000 + independent_move;
    check(slave_position, exp_pos);
    cam_arm(1'b0);
    check(cam_engaged, 0);
    check(slave_position, exp_pos);
  endtask

  // ====================
  // main sequence
  initial
  begin
    {clk, gear_ratio_load, gantry_option, stop_command, limit_hit,
      reverse_trip_arm, forward_trip_arm, cam_master_select,
      slave_change_negative, cam_table_write, cam_mode_enable, cam_engage_arm,
      cam_disengage_arm, gear_master_select, cam_table_index,
      gear_ramp_distance, master_cycle_modulus, slave_cycle_change,
      cam_interval_width, cam_phase_offset, auxiliary_encoder_source,
      vector_source, step, gear_ratio_set, independent_move,
      reverse_position_trippoint, forward_position_trippoint, cam_table_entry,
      cam_engage_point, cam_disengage_point} = '0;
    exp_pos = 0;
    ratio_now = 0;
    rst = 1'b1;
    tick(16);
    rst <= 1'b0;
    tick(2);
    gear_follow();
    gear_stop();
    trip(exp_pos + 50, 32'sh8000_0000, 32'sh0000_0064, 1'b1);
    trip(32'sh7FFF_FFFF, exp_pos - 50, -32'sh0000_0064, 1'b0);
    gear_ramp();
    cam_run();
    conclude();
  end
endmodule // gearing_and_cam_follower_tb
